// ===== inc/twf_pkg.sv
// Shared constants and types of the transmit wait and framing control block
`default_nettype none
package twf_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_WAIT_CTRL   = 8'h31;
   localparam logic [7:0] ADDR_WAIT_LOW    = 8'h32;
   localparam logic [7:0] ADDR_FRAME_CTRL  = 8'h33;
   localparam logic [7:0] ADDR_STATUS      = 8'h3C;
   // Reset values
   localparam logic [7:0] RST_WAIT_CTRL    = 8'hC0;
   localparam logic [7:0] RST_WAIT_LOW     = 8'h00;
   localparam logic [7:0] RST_FRAME_CTRL   = 8'h00;
   // Wait control fields
   localparam int         POS_ORIGIN       = 7;
   localparam int         POS_UNIT         = 6;
   localparam int         POS_UPPER_HI     = 5;
   localparam int         POS_UPPER_LO     = 3;
   localparam int         POS_STOP_HI      = 2;
   localparam int         POS_STOP_LO      = 0;
   // Frame control fields
   localparam int         POS_TX_PAR       = 7;
   localparam int         POS_RX_PAR       = 6;
   localparam int         POS_END_HI       = 3;
   localparam int         POS_END_LO       = 2;
   localparam int         POS_BEGIN_HI     = 1;
   localparam int         POS_BEGIN_LO     = 0;
   localparam logic [7:0] FRAME_CTRL_MASK  = 8'hCF;
   // Status fields
   localparam int         POS_ST_HOLD      = 0;
   localparam int         POS_ST_BUSY      = 1;
   localparam int         POS_ST_PERR      = 2;
   // Widths
   localparam int         HOLD_W           = 11;
   localparam int         BYTE_BITS        = 8;
   // Carrier unit: 16 periods of 13.56 MHz, least time so rounded up
   localparam int         CLK_HZ           = 10_000_000;
   localparam int         CARRIER_HZ       = 13_560_000;
   localparam int         CARRIER_PER_UNIT = 16;
   localparam int         CARRIER_UNIT_CYC =
      (CARRIER_PER_UNIT * CLK_HZ + CARRIER_HZ - 1) / CARRIER_HZ;
   // Odd parity on the air
   localparam logic       PARITY_ODD       = 1'b1;
   localparam logic [1:0] SYM_NONE         = 2'h0;
   localparam logic [2:0] STOP_NONE        = 3'h0;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } twf_bus_req_type;

   typedef enum logic [2:0] {
      KIND_DATA,
      KIND_PARITY,
      KIND_STOP,
      KIND_GUARD,
      KIND_SYMBOL
   } twf_kind_type;

   typedef struct packed {
      logic         valid;
      logic         value;
      twf_kind_type kind;
      logic [1:0]   sym;
   } twf_tx_bit_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       parity;
   } twf_rx_byte_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } twf_fifo_wr_type;
endpackage
`default_nettype wire

// ===== logic/twf_holdoff.sv
// Transmit holdoff timer with carrier unit divider
`default_nettype none
module twf_holdoff
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        start,
   input  wire logic [twf_pkg::HOLD_W-1:0]  value,
   input  wire logic                        unit_bits,
   input  wire logic                        half_bit_tick,
   output logic                             done
);
   typedef struct packed {
      logic [twf_pkg::HOLD_W-1:0] count;
      logic [4:0]                 div;
   } twf_hold_state_type;

   twf_hold_state_type s_reg;
   twf_hold_state_type s_next;
   logic               unit_tick;

   always_comb
   begin
      s_next = s_reg;
      unit_tick = 1'b0;
      if (unit_bits)
         unit_tick = half_bit_tick;
      else if (s_reg.div == 5'(twf_pkg::CARRIER_UNIT_CYC - 1))
         unit_tick = 1'b1;
      if (unit_tick || start)
         s_next.div = 5'h00;
      else
         s_next.div = s_reg.div + 5'h01;
      // A restart reloads the full value, so the gap counts from the latest end
      if (start)
         s_next.count = value;
      else if (unit_tick && s_reg.count != '0)
         s_next.count = s_reg.count - 11'h001;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign done = (s_reg.count == '0) && !start;
endmodule
`default_nettype wire

// ===== logic/twf_top.sv
// Transmit holdoff, stop and guard time, symbol selection and parity framing
`default_nettype none
module twf_top
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  var  twf_pkg::twf_bus_req_type bus_req,
   output logic [7:0]                    bus_rdata,
   input  wire logic                     type_b_mode,
   input  wire logic                     bit_tick,
   input  wire logic                     half_bit_tick,
   input  wire logic                     rx_end,
   input  wire logic                     tx_valid,
   input  wire logic [7:0]               tx_data,
   input  wire logic                     tx_last,
   output logic                          tx_ready,
   output twf_pkg::twf_tx_bit_type       tx_bit,
   output logic                          tx_end,
   input  var  twf_pkg::twf_rx_byte_type rx_byte,
   output twf_pkg::twf_fifo_wr_type      fifo_wr,
   output logic                          rx_parity_error
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOAD,
      ST_DATA,
      ST_PARITY,
      ST_STOP,
      ST_GUARD,
      ST_END
   } twf_state_type;

   typedef struct packed {
      logic [7:0]               wait_ctrl;
      logic [7:0]               wait_low;
      logic [7:0]               frame_ctrl;
      logic [7:0]               rdata;
      twf_state_type            st;
      logic [7:0]               shreg;
      logic [2:0]               bitn;
      logic                     par;
      logic                     last;
      logic [2:0]               guards;
      logic                     perr;
      logic                     tx_end;
      twf_pkg::twf_tx_bit_type  out;
      twf_pkg::twf_fifo_wr_type fifo;
   } twf_top_state_type;

   twf_top_state_type           s_reg;
   twf_top_state_type           s_next;
   logic [twf_pkg::HOLD_W-1:0]  hold_value;
   logic                        hold_start;
   logic                        hold_done;
   logic                        origin_rx;
   logic                        unit_bits;
   logic [2:0]                  stop_len;
   logic                        stop_active;
   logic [1:0]                  end_sym;
   logic [1:0]                  begin_sym;
   logic                        tx_par_en;
   logic                        rx_par_en;
   logic                        rx_bad;
   logic [7:0]                  status;

   assign origin_rx  = s_reg.wait_ctrl[twf_pkg::POS_ORIGIN];
   assign unit_bits  = s_reg.wait_ctrl[twf_pkg::POS_UNIT];
   assign hold_value = {s_reg.wait_ctrl[twf_pkg::POS_UPPER_HI:twf_pkg::POS_UPPER_LO],
                        s_reg.wait_low};
   assign stop_len   = s_reg.wait_ctrl[twf_pkg::POS_STOP_HI:twf_pkg::POS_STOP_LO];
   assign stop_active = type_b_mode && (stop_len != twf_pkg::STOP_NONE);
   assign tx_par_en  = s_reg.frame_ctrl[twf_pkg::POS_TX_PAR];
   assign rx_par_en  = s_reg.frame_ctrl[twf_pkg::POS_RX_PAR];
   assign end_sym    = s_reg.frame_ctrl[twf_pkg::POS_END_HI:twf_pkg::POS_END_LO];
   assign begin_sym  = s_reg.frame_ctrl[twf_pkg::POS_BEGIN_HI:twf_pkg::POS_BEGIN_LO];

   // Restart source chosen by the origin bit
   assign hold_start = origin_rx ? rx_end : s_reg.tx_end;

   twf_holdoff u_holdoff
   (
      .clk           (clk),
      .rst_n         (rst_n),
      .start         (hold_start),
      .value         (hold_value),
      .unit_bits     (unit_bits),
      .half_bit_tick (half_bit_tick),
      .done          (hold_done)
   );

   // Odd parity wants the inverse of the xor of the data bits
   assign rx_bad = rx_byte.valid && rx_par_en
                   && ((^rx_byte.data ^ twf_pkg::PARITY_ODD) != rx_byte.parity);

   always_comb
   begin
      status = 8'h00;
      status[twf_pkg::POS_ST_HOLD] = !hold_done;
      status[twf_pkg::POS_ST_BUSY] = (s_reg.st != ST_IDLE);
      status[twf_pkg::POS_ST_PERR] = s_reg.perr;
   end

   assign tx_ready = (s_reg.st == ST_LOAD);

   always_comb
   begin
      s_next = s_reg;
      s_next.tx_end = 1'b0;
      s_next.out.valid = 1'b0;
      s_next.fifo.valid = 1'b0;

      // Register writes
      if (bus_req.wr)
      begin
         case (bus_req.addr)
            twf_pkg::ADDR_WAIT_CTRL:  s_next.wait_ctrl = bus_req.wdata;
            twf_pkg::ADDR_WAIT_LOW:   s_next.wait_low = bus_req.wdata;
            twf_pkg::ADDR_FRAME_CTRL: s_next.frame_ctrl = bus_req.wdata & twf_pkg::FRAME_CTRL_MASK;
            twf_pkg::ADDR_STATUS:
               if (bus_req.wdata[twf_pkg::POS_ST_PERR])
                  s_next.perr = 1'b0;
            default: ;
         endcase
      end

      // Register reads, data valid in the following cycle only
      s_next.rdata = 8'h00;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            twf_pkg::ADDR_WAIT_CTRL:  s_next.rdata = s_reg.wait_ctrl;
            twf_pkg::ADDR_WAIT_LOW:   s_next.rdata = s_reg.wait_low;
            twf_pkg::ADDR_FRAME_CTRL: s_next.rdata = s_reg.frame_ctrl;
            twf_pkg::ADDR_STATUS:     s_next.rdata = status;
            default:                  s_next.rdata = 8'h00;
         endcase
      end

      // Receive path; a new error beats a clear in the same cycle
      if (rx_byte.valid)
      begin
         s_next.fifo.valid = 1'b1;
         s_next.fifo.data = rx_byte.data;
      end
      if (rx_bad)
         s_next.perr = 1'b1;

      // Transmit framer, one bit per bit tick
      case (s_reg.st)
         ST_IDLE:
            if (tx_valid && hold_done && bit_tick)
            begin
               if (begin_sym != twf_pkg::SYM_NONE)
               begin
                  s_next.out.valid = 1'b1;
                  s_next.out.value = 1'b0;
                  s_next.out.kind = twf_pkg::KIND_SYMBOL;
                  s_next.out.sym = begin_sym - 2'h1;
               end
               s_next.st = ST_LOAD;
            end
         ST_LOAD:
            if (tx_valid)
            begin
               s_next.shreg = tx_data;
               s_next.last = tx_last;
               s_next.bitn = 3'h0;
               s_next.par = 1'b0;
               s_next.st = ST_DATA;
            end
         ST_DATA:
            if (bit_tick)
            begin
               s_next.out.valid = 1'b1;
               s_next.out.value = s_reg.shreg[0];
               s_next.out.kind = twf_pkg::KIND_DATA;
               s_next.par = s_reg.par ^ s_reg.shreg[0];
               s_next.shreg = {1'b0, s_reg.shreg[7:1]};
               s_next.bitn = s_reg.bitn + 3'h1;
               if (s_reg.bitn == 3'(twf_pkg::BYTE_BITS - 1))
               begin
                  if (tx_par_en)
                     s_next.st = ST_PARITY;
                  else if (stop_active)
                     s_next.st = ST_STOP;
                  else
                     s_next.st = s_reg.last ? ST_END : ST_LOAD;
               end
            end
         ST_PARITY:
            if (bit_tick)
            begin
               s_next.out.valid = 1'b1;
               s_next.out.value = s_reg.par ^ twf_pkg::PARITY_ODD;
               s_next.out.kind = twf_pkg::KIND_PARITY;
               if (stop_active)
                  s_next.st = ST_STOP;
               else
                  s_next.st = s_reg.last ? ST_END : ST_LOAD;
            end
         ST_STOP:
            if (bit_tick)
            begin
               s_next.out.valid = 1'b1;
               s_next.out.value = 1'b1;
               s_next.out.kind = twf_pkg::KIND_STOP;
               s_next.guards = stop_len - 3'h1;
               if (stop_len > 3'h1)
                  s_next.st = ST_GUARD;
               else
                  s_next.st = s_reg.last ? ST_END : ST_LOAD;
            end
         ST_GUARD:
            if (bit_tick)
            begin
               s_next.out.valid = 1'b1;
               s_next.out.value = 1'b1;
               s_next.out.kind = twf_pkg::KIND_GUARD;
               s_next.guards = s_reg.guards - 3'h1;
               if (s_reg.guards == 3'h1)
                  s_next.st = s_reg.last ? ST_END : ST_LOAD;
            end
         ST_END:
            if (bit_tick)
            begin
               if (end_sym != twf_pkg::SYM_NONE)
               begin
                  s_next.out.valid = 1'b1;
                  s_next.out.value = 1'b0;
                  s_next.out.kind = twf_pkg::KIND_SYMBOL;
                  s_next.out.sym = end_sym - 2'h1;
               end
               s_next.tx_end = 1'b1;
               s_next.st = ST_IDLE;
            end
         default:
            s_next.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg <= '0;
         s_reg.wait_ctrl <= twf_pkg::RST_WAIT_CTRL;
         s_reg.wait_low <= twf_pkg::RST_WAIT_LOW;
         s_reg.frame_ctrl <= twf_pkg::RST_FRAME_CTRL;
         s_reg.st <= ST_IDLE;
      end
      else
         s_reg <= s_next;
   end

   assign bus_rdata       = s_reg.rdata;
   assign tx_bit          = s_reg.out;
   assign tx_end          = s_reg.tx_end;
   assign fifo_wr         = s_reg.fifo;
   assign rx_parity_error = s_reg.perr;
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench of the framing block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                      clk = 1'b0;
   logic                      rst_n = 1'b0;
   twf_pkg::twf_bus_req_type  bus_req = '0;
   logic [7:0]                bus_rdata;
   logic                      type_b_mode = 1'b0;
   logic                      bit_tick = 1'b0;
   logic                      half_bit_tick = 1'b0;
   logic                      rx_end;
   logic                      tx_valid = 1'b0;
   logic [7:0]                tx_data = 8'h00;
   logic                      tx_last = 1'b0;
   logic                      tx_ready;
   twf_pkg::twf_tx_bit_type   tx_bit;
   logic                      tx_end;
   twf_pkg::twf_rx_byte_type  rx_byte;
   twf_pkg::twf_fifo_wr_type  fifo_wr;
   logic                      rx_parity_error;
   int                        failures = 0;
   int                        n_checks = 0;
   int                        cyc = 0;
   int                        n;
   int                        r;
   logic [7:0]                d;
   logic [7:0]                wc;
   logic [7:0]                wl;
   logic [7:0]                fc;
   logic [5:0]                exp_q[$];
   logic [15:0]               since_tx = 16'h0;
   logic [15:0]               since_rx = 16'h0;
   logic [15:0]               gap;
   logic [15:0]               treq;
   logic [15:0]               hold;
   logic                      arm = 1'b0;
   logic                      org = 1'b0;
   twf_top uut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .type_b_mode(type_b_mode),
      .bit_tick(bit_tick), .half_bit_tick(half_bit_tick), .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready), .tx_bit(tx_bit), .tx_end(tx_end), .rx_byte(rx_byte),
      .fifo_wr(fifo_wr), .rx_parity_error(rx_parity_error));
   twf_card_model card (.clk(clk), .tx_bit(tx_bit), .tx_end(tx_end), .rx_byte(rx_byte), .rx_end(rx_end));
   initial
   begin
      forever #50 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      n_checks++;
      if (got !== want)
      begin
         failures++;
         $display("[ERR] %0t got %h want %h", $time, got, want);
      end
   endtask
   // Holdoff in clock cycles: carrier unit rounded up to whole cycles, bit unit is one half bit of 4 cycles
   function automatic logic [15:0] hold_cycles(input logic [7:0] c, input logic [7:0] l);
      return 16'({c[5:3], l}) * (c[6] ? 16'h4 : 16'(twf_pkg::CARRIER_UNIT_CYC));
   endfunction
   // Bit period 8 cycles, half bit 4; run capped well above the expected length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      bit_tick <= cyc % 8 == 7;
      half_bit_tick <= cyc % 4 == 3;
      if (cyc == 100000)
      begin
         failures++;
         conclude();
      end
   end
   always @(negedge clk)
   begin
      since_tx = (tx_end === 1'b1) ? 16'h0 : since_tx + 16'h1;
      since_rx = (rx_end === 1'b1) ? 16'h0 : since_rx + 16'h1;
      if (arm && tx_bit.valid === 1'b1)
      begin
         arm = 1'b0;
         gap = org ? since_rx : since_tx;
      end
      if (fifo_wr.valid === 1'b1)
         check(16'(fifo_wr.data), 16'(card.rxq.pop_front()));
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      bus_req <= '{1'b1, 1'b0, a, v};
      @(posedge clk);
      bus_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      bus_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus_req <= '0;
      @(negedge clk);
      v = bus_rdata;
   endtask
   task automatic frame(input int nb, input logic chk);
      logic [7:0] b;
      logic       tb;
      tb = type_b_mode && wc[2:0] != 3'h0;
      exp_q.delete();
      card.q.delete();
      if (fc[1:0] != 2'h0)
         exp_q.push_back({twf_pkg::KIND_SYMBOL, 1'b0, fc[1:0] - 2'h1});
      n = card.n_end;
      arm = chk;
      treq = org ? since_rx : since_tx;
      for (int k = 0; k < nb; k++)
      begin
         b = 8'($urandom);
         @(posedge clk);
         tx_valid <= 1'b1;
         tx_data <= b;
         tx_last <= k == nb - 1;
         for (int j = 0; j < 8; j++)
            exp_q.push_back({twf_pkg::KIND_DATA, b[j], 2'h0});
         if (fc[7])
            exp_q.push_back({twf_pkg::KIND_PARITY, ~^b, 2'h0});
         if (tb)
            exp_q.push_back({twf_pkg::KIND_STOP, 1'b0, 2'h0});
         for (int j = 1; tb && j < wc[2:0]; j++)
            exp_q.push_back({twf_pkg::KIND_GUARD, 1'b1, 2'h0});
         do @(negedge clk); while (tx_ready !== 1'b1);
      end
      @(posedge clk);
      tx_valid <= 1'b0;
      if (fc[3:2] != 2'h0)
         exp_q.push_back({twf_pkg::KIND_SYMBOL, 1'b0, fc[3:2] - 2'h1});
      wait (card.n_end != n);
      @(negedge clk);
      check(16'(card.q.size()), 16'(exp_q.size()));
      foreach (exp_q[k])
         check(16'(card.q[k]), 16'(exp_q[k]));
      // Start waits for the next tick; bit units may lose up to one half bit
      if (chk)
      begin
         check(16'(gap + (wc[6] ? 16'h4 : 16'h0) >= hold), 16'h1);
         check(16'(gap <= (hold > treq ? hold : treq) + 16'h1A), 16'h1);
      end
   endtask
   initial
   begin
      void'($urandom(32'h04D4E8C2));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(twf_pkg::ADDR_WAIT_CTRL, d);
      check(16'(d), 16'hC0);
      rd(8'h40, d);
      check(16'(d), 16'h0);
      wr(8'h40, 8'hFF);
      fc = 8'($urandom);
      wr(twf_pkg::ADDR_FRAME_CTRL, fc);
      rd(twf_pkg::ADDR_FRAME_CTRL, d);
      check(16'(d), 16'(fc & 8'hCF));
      $display("register test done");
      for (int i = 0; i < 16; i++)
      begin
         wc = {i[0], i[1], i[1] & i[2] & ~i[3], 1'b0, i[0] & ~i[1] & ~i[3], i[2:0]};
         wl = {2'b01, 6'($urandom)};
         fc = {i[0] ^ i[1], 1'($urandom), 2'($urandom), i[3:2], i[1:0]};
         org = wc[7];
         hold = hold_cycles(wc, wl);
         wr(twf_pkg::ADDR_WAIT_CTRL, wc);
         type_b_mode <= i[3];
         wr(twf_pkg::ADDR_WAIT_LOW, wl);
         wr(twf_pkg::ADDR_FRAME_CTRL, fc);
         wr(twf_pkg::ADDR_STATUS, 8'h04);
         r = card.n_resp;
         frame(1 + i % 3, 1'b0);
         wait (card.n_resp != r);
         rd(twf_pkg::ADDR_STATUS, d);
         check(16'(d[2]), 16'(fc[6] & card.bad_any));
         check(16'(d[0]), 16'h1);
         check(16'(d[1]), 16'h0);
         check(16'(rx_parity_error), 16'(fc[6] & card.bad_any));
         r = card.n_resp;
         frame(2, 1'b1);
         wait (card.n_resp != r);
         $display("frame test %0d done", i);
      end
      conclude();
   end
endmodule
bind twf_top twf_top_props u_props (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .type_b_mode(type_b_mode), .bit_tick(bit_tick), .half_bit_tick(half_bit_tick), .rx_end(rx_end),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_bit(tx_bit),
   .tx_end(tx_end), .rx_byte(rx_byte), .fifo_wr(fifo_wr), .rx_parity_error(rx_parity_error));
`default_nettype wire

// ===== testbench/twf_card_model.sv
// Card model: collects emitted bits and answers each frame
`default_nettype none
module twf_card_model
(
   input wire logic                     clk,
   input var  twf_pkg::twf_tx_bit_type  tx_bit,
   input wire logic                     tx_end,
   output var twf_pkg::twf_rx_byte_type rx_byte,
   output var logic                     rx_end
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] q[$];
   logic [7:0] rxq[$];
   logic       bad_any = 1'b0;
   logic [7:0] b;
   logic       bad;
   int         n_end = 0;
   int         n_resp = 0;
   // Stop value is not compared, symbol code only for symbols
   always @(negedge clk)
   begin
      if (tx_bit.valid === 1'b1)
         q.push_back({tx_bit.kind, tx_bit.kind != twf_pkg::KIND_STOP && tx_bit.value,
                      tx_bit.kind == twf_pkg::KIND_SYMBOL ? tx_bit.sym : 2'h0});
      if (tx_end === 1'b1)
         n_end++;
   end
   initial
   begin
      rx_byte = '0;
      rx_end = 1'b0;
      forever
      begin
         @(negedge clk);
         if (tx_end === 1'b1)
         begin
            bad_any = 1'b0;
            repeat (20) @(posedge clk);
            for (int k = 0; k < 2; k++)
            begin
               b = 8'($urandom);
               bad = 1'($urandom);
               rx_byte <= '{1'b1, b, ~^b ^ bad};
               rxq.push_back(b);
               bad_any = bad_any | bad;
               @(posedge clk);
               // Released byte lines show a changed pattern, never the last byte
               rx_byte <= '{1'b0, ~b, ^b ^ bad};
               repeat (3) @(posedge clk);
            end
            rx_end <= 1'b1;
            @(posedge clk);
            rx_end <= 1'b0;
            n_resp++;
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/twf_top_props.sv
// Concurrent checks on the framing block ports
`default_nettype none
module twf_top_props
(
   input wire logic                     clk,
   input wire logic                     rst_n,
   input var  twf_pkg::twf_bus_req_type bus_req,
   input wire logic [7:0]               bus_rdata,
   input wire logic                     type_b_mode,
   input wire logic                     bit_tick,
   input wire logic                     half_bit_tick,
   input wire logic                     rx_end,
   input wire logic                     tx_valid,
   input wire logic [7:0]               tx_data,
   input wire logic                     tx_last,
   input wire logic                     tx_ready,
   input var  twf_pkg::twf_tx_bit_type  tx_bit,
   input wire logic                     tx_end,
   input var  twf_pkg::twf_rx_byte_type rx_byte,
   input var  twf_pkg::twf_fifo_wr_type fifo_wr,
   input wire logic                     rx_parity_error
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic clr;
   logic tv;
   // Clear strobe for the sticky parity flag
   assign clr = bus_req.wr && bus_req.addr == twf_pkg::ADDR_STATUS && bus_req.wdata[twf_pkg::POS_ST_PERR];
   assign tv = tx_bit.valid;
   property p_follow;
      rx_byte.valid |=> fifo_wr.valid && fifo_wr.data == $past(rx_byte.data);
   endproperty
   a_rdata_after_rd: assert property (bus_rdata != 8'h00 |-> $past(bus_req.rd))
      else $error("read data without a read");
   a_fifo_follows_rx: assert property (p_follow)
      else $error("fifo write missing or wrong");
   a_fifo_needs_rx: assert property (fifo_wr.valid |-> $past(rx_byte.valid))
      else $error("fifo write without a byte");
   a_bit_on_tick: assert property (tv |-> $past(bit_tick))
      else $error("bit emitted without a tick");
   a_end_on_tick: assert property (tx_end |-> $past(bit_tick))
      else $error("frame end without a tick");
   a_stop_typeb: assert property (tv && tx_bit.kind inside {twf_pkg::KIND_STOP, twf_pkg::KIND_GUARD}
      |-> type_b_mode)
      else $error("stop or guard outside type B");
   a_guard_high: assert property (tv && tx_bit.kind == twf_pkg::KIND_GUARD |-> tx_bit.value)
      else $error("guard bit not high");
   a_sym_code: assert property (tv && tx_bit.kind == twf_pkg::KIND_SYMBOL
      |-> !tx_bit.value && tx_bit.sym != 2'h3)
      else $error("bad symbol selection");
   a_perr_sticky: assert property ($past(rx_parity_error) && !$past(clr) |-> rx_parity_error)
      else $error("parity error dropped");
   a_perr_cause: assert property ($rose(rx_parity_error) |-> $past(rx_byte.valid))
      else $error("parity error without a byte");
   c_end: cover property (tx_end);
   c_perr: cover property ($rose(rx_parity_error));
   c_guard: cover property (tv && tx_bit.kind == twf_pkg::KIND_GUARD);
endmodule
`default_nettype wire
